// ==== hdl/ovs_core.sv ====
// supply monitor status, interrupt, indicator decode and supply control
//
// Summary of operation
// R1: session-over flag goes 0 to 1 when bus falls below session-end threshold.
// R2: session-over comparator off only when both edge enables clear; reads 0.
// R3: session-present enables gate interrupts only; live state stays readable.
// R4: supply-good comparator off when both enables clear; status bit 1 reads 0.
// R5: external supply indicator is tied to logic one internally.
// R6: after reset indicator decoding is off; internal comparator is reported.
// R7: select clear reports internal comparator regardless of pass and invert.
// R8: select set: pass-only gives 1, invert gives 0, neither gives comparator.
// R9: a peripheral link starts on session-present, not on supply-good.
// R10: drain resistor follows otg control bit 3.
// R11: lift resistor follows otg control bit 4.
// R12: dedicated active-high external supply enable output.
// R13: external supply enable is OR of internal and external drive bits.
// R14: both drive bits clear at reset, supply enable starts low.
// R15: entering uart mode switches regulator to the uart level field.
// R16: in uart mode line levels are not presented on the low data lines.
// R17: comparator outputs pass a two-flop synchroniser before use.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module ovs_core (
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    input  wire ovs_pkg::ovs_bus_req_s         reg_req,
    output logic [ovs_pkg::DATA_W-1:0]         reg_rdata,
    input  wire ovs_pkg::ovs_cmp_s             cmp_raw,
    input  wire logic [1:0]                    linestate_in,
    output logic                               cmp_supply_good_en,
    output logic                               cmp_session_over_en,
    output logic                               supply_drain_ctl,
    output logic                               supply_lift_ctl,
    output logic                               ext_supply_enable_out,
    output logic [ovs_pkg::LVL_W-1:0]          regulator_level,
    output logic                               uart_active,
    output logic [1:0]                         rxcmd_vbus_state,
    output logic [1:0]                         linestate_data,
    output logic                               irq
);
    ovs_pkg::ovs_state_s st_ff;
    ovs_pkg::ovs_state_s nxt_st;
    ovs_pkg::ovs_cmp_s   sync_cmp;
    ovs_pkg::ovs_cmp_s   live;
    logic [ovs_pkg::DATA_W-1:0] live_b;
    logic [ovs_pkg::DATA_W-1:0] prev_b;
    logic [ovs_pkg::DATA_W-1:0] evt;
    logic [ovs_pkg::DATA_W-1:0] clr;
    logic [ovs_pkg::DATA_W-1:0] rd_mux;
    logic                       vbus_valid;
    logic [ovs_pkg::LVL_W-1:0]  uart_lvl;
    logic [ovs_pkg::LVL_W-1:0]  norm_lvl;
    logic                       uart_req;

    function automatic logic [ovs_pkg::DATA_W-1:0] cmp_to_byte(input ovs_pkg::ovs_cmp_s c);
        logic [ovs_pkg::DATA_W-1:0] b;
        b = 8'h00;
        b[ovs_pkg::BIT_SUPPLY_GOOD]     = c.supply_good;
        b[ovs_pkg::BIT_SESSION_PRESENT] = c.session_present;
        b[ovs_pkg::BIT_SESSION_OVER]    = c.session_over;
        return b;
    endfunction

    // R17: synchronise comparators
    ovs_sync #(
        .W ($bits(ovs_pkg::ovs_cmp_s))
    ) u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d       (cmp_raw),
        .q       (sync_cmp)
    );

    // R2: session-over enabled by either edge enable
    assign cmp_session_over_en = st_ff.en_rise[ovs_pkg::BIT_SESSION_OVER]
                               | st_ff.en_fall[ovs_pkg::BIT_SESSION_OVER];
    // R4: supply-good enabled by either edge enable
    assign cmp_supply_good_en  = st_ff.en_rise[ovs_pkg::BIT_SUPPLY_GOOD]
                               | st_ff.en_fall[ovs_pkg::BIT_SUPPLY_GOOD];

    // disabled comparators read as zero; session-present is never disabled
    always_comb begin
        live.session_over    = sync_cmp.session_over & cmp_session_over_en;
        // R3: session-present always live
        live.session_present = sync_cmp.session_present;
        live.supply_good     = sync_cmp.supply_good & cmp_supply_good_en;
    end

    assign live_b = cmp_to_byte(live);
    assign prev_b = cmp_to_byte(st_ff.prev);

    // R1: rising session-over is an event
    assign evt = ((live_b & ~prev_b & st_ff.en_rise)
                | (~live_b & prev_b & st_ff.en_fall)) & ovs_pkg::STAT_MASK;

    assign clr = (reg_req.wr && reg_req.addr == ovs_pkg::ADDR_LATCH) ? reg_req.wdata : 8'h00;

    // R5: indicator decode
    ovs_vbus_src u_vbus_src (
        .internal_good (live.supply_good),
        .cfg           (st_ff.ext_cfg),
        .vbus_valid    (vbus_valid)
    );

    assign uart_lvl = st_ff.io_pwr[ovs_pkg::UART_LVL_LSB +: ovs_pkg::LVL_W];
    assign norm_lvl = st_ff.io_pwr[ovs_pkg::NORM_LVL_LSB +: ovs_pkg::LVL_W];
    assign uart_req = st_ff.io_pwr[ovs_pkg::BIT_UART_MODE];

    always_comb begin
        if (reg_req.addr == ovs_pkg::ADDR_EN_RISE) begin
            rd_mux = st_ff.en_rise;
        end else if (reg_req.addr == ovs_pkg::ADDR_EN_FALL) begin
            rd_mux = st_ff.en_fall;
        end else if (reg_req.addr == ovs_pkg::ADDR_STATUS) begin
            // R3: live comparator state
            rd_mux = live_b;
        end else if (reg_req.addr == ovs_pkg::ADDR_LATCH) begin
            rd_mux = st_ff.latch;
        end else if (reg_req.addr == ovs_pkg::ADDR_MASK) begin
            rd_mux = st_ff.mask;
        end else if (reg_req.addr == ovs_pkg::ADDR_OTG) begin
            rd_mux = st_ff.otg;
        end else if (reg_req.addr == ovs_pkg::ADDR_IO_PWR) begin
            rd_mux = st_ff.io_pwr;
        end else if (reg_req.addr == ovs_pkg::ADDR_EXT_CFG) begin
            rd_mux = {5'h00, st_ff.ext_cfg};
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        if (reg_req.wr) begin
            if (reg_req.addr == ovs_pkg::ADDR_EN_RISE) begin
                nxt_st.en_rise = reg_req.wdata & ovs_pkg::STAT_MASK;
            end else if (reg_req.addr == ovs_pkg::ADDR_EN_FALL) begin
                nxt_st.en_fall = reg_req.wdata & ovs_pkg::STAT_MASK;
            end else if (reg_req.addr == ovs_pkg::ADDR_MASK) begin
                nxt_st.mask = reg_req.wdata & ovs_pkg::STAT_MASK;
            end else if (reg_req.addr == ovs_pkg::ADDR_OTG) begin
                nxt_st.otg = reg_req.wdata & ovs_pkg::OTG_MASK;
            end else if (reg_req.addr == ovs_pkg::ADDR_IO_PWR) begin
                nxt_st.io_pwr = reg_req.wdata;
            end else if (reg_req.addr == ovs_pkg::ADDR_EXT_CFG) begin
                nxt_st.ext_cfg = reg_req.wdata[2:0];
            end
        end
        // set wins over a same-cycle clear
        nxt_st.latch = ((st_ff.latch & ~clr) | evt) & ovs_pkg::STAT_MASK;
        nxt_st.prev  = live;
        // read data stand one cycle only
        nxt_st.rdata = reg_req.rd ? rd_mux : 8'h00;
        if (vbus_valid) begin
            nxt_st.rxcmd = ovs_pkg::VBUS_VALID;
        end else if (live.session_present) begin
            nxt_st.rxcmd = ovs_pkg::VBUS_SESS_TO_VALID;
        end else if (!live.session_over) begin
            nxt_st.rxcmd = ovs_pkg::VBUS_END_TO_SESS;
        end else begin
            nxt_st.rxcmd = ovs_pkg::VBUS_BELOW_END;
        end
        // R15: uart selects uart regulator level
        nxt_st.mode    = uart_req ? ovs_pkg::MODE_UART : ovs_pkg::MODE_SYNC;
        nxt_st.reg_lvl = uart_req ? uart_lvl : norm_lvl;
        // R16: line levels withheld in uart
        nxt_st.linestate = uart_req ? 2'h0 : linestate_in;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_ff.en_rise   <= ovs_pkg::EN_RST;
            st_ff.en_fall   <= ovs_pkg::EN_RST;
            st_ff.latch     <= ovs_pkg::REG_RST;
            st_ff.mask      <= ovs_pkg::REG_RST;
            // R14: drive bits clear at reset
            st_ff.otg       <= ovs_pkg::REG_RST;
            st_ff.io_pwr    <= ovs_pkg::REG_RST;
            // R6: indicator decode off at reset
            st_ff.ext_cfg   <= '0;
            st_ff.prev      <= '0;
            st_ff.rdata     <= 8'h00;
            st_ff.rxcmd     <= ovs_pkg::VBUS_BELOW_END;
            st_ff.mode      <= ovs_pkg::MODE_SYNC;
            st_ff.reg_lvl   <= 2'h0;
            st_ff.linestate <= 2'h0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata        = st_ff.rdata;
    // R10: drain resistor control
    assign supply_drain_ctl = st_ff.otg[ovs_pkg::BIT_DRAIN];
    // R11: lift resistor control
    assign supply_lift_ctl  = st_ff.otg[ovs_pkg::BIT_LIFT];
    // R12: R13: supply enable OR
    assign ext_supply_enable_out = st_ff.otg[ovs_pkg::BIT_INT_DRIVE]
                                 | st_ff.otg[ovs_pkg::BIT_EXT_DRIVE];
    assign regulator_level  = st_ff.reg_lvl;
    assign uart_active      = (st_ff.mode == ovs_pkg::MODE_UART);
    assign rxcmd_vbus_state = st_ff.rxcmd;
    assign linestate_data   = st_ff.linestate;
    // level interrupt from masked sticky bits
    assign irq              = |(st_ff.latch & st_ff.mask);

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_status_rd;
        reg_req.rd && reg_req.addr == ovs_pkg::ADDR_STATUS;
    endsequence

    sequence s_uart_enter;
        reg_req.wr && reg_req.addr == ovs_pkg::ADDR_IO_PWR
            && reg_req.wdata[ovs_pkg::BIT_UART_MODE] ##1 1'b1;
    endsequence

    AST_OVER_RISE_LATCH: assert property ( // R1
        !st_ff.prev.session_over && live.session_over
            && st_ff.en_rise[ovs_pkg::BIT_SESSION_OVER]
        |=> st_ff.latch[ovs_pkg::BIT_SESSION_OVER])
        else $error("session-over rise not latched");

    AST_OVER_OFF_ZERO: assert property ( // R2
        s_status_rd and !cmp_session_over_en
        |=> !reg_rdata[ovs_pkg::BIT_SESSION_OVER])
        else $error("disabled session-over read nonzero");

    AST_PRESENT_LIVE: assert property ( // R3
        s_status_rd |=> reg_rdata[ovs_pkg::BIT_SESSION_PRESENT]
            == $past(sync_cmp.session_present))
        else $error("session-present not live in status");

    AST_GOOD_OFF_ZERO: assert property ( // R4
        s_status_rd and !cmp_supply_good_en
        |=> !reg_rdata[ovs_pkg::BIT_SUPPLY_GOOD])
        else $error("disabled supply-good read nonzero");

    AST_RESET_STATE: assert property (@(posedge sys_clk) disable iff (1'b0) // R14
        sys_rst |=> !ext_supply_enable_out && !st_ff.ext_cfg.use_ext)
        else $error("drive bits or decode not cleared by reset");

    AST_INTERNAL_SRC: assert property ( // R7
        !st_ff.ext_cfg.use_ext |=> (rxcmd_vbus_state == ovs_pkg::VBUS_VALID)
            == $past(live.supply_good))
        else $error("internal source not reported");

    AST_COMPL_ZERO: assert property ( // R8
        st_ff.ext_cfg.use_ext && st_ff.ext_cfg.compl
        |=> rxcmd_vbus_state != ovs_pkg::VBUS_VALID)
        else $error("complement did not force zero");

    AST_DRAIN_ON: assert property ( // R10
        reg_req.wr && reg_req.addr == ovs_pkg::ADDR_OTG && reg_req.wdata[ovs_pkg::BIT_DRAIN]
        |=> supply_drain_ctl)
        else $error("drain resistor not switched on");

    AST_LIFT_OFF: assert property ( // R11
        reg_req.wr && reg_req.addr == ovs_pkg::ADDR_OTG && !reg_req.wdata[ovs_pkg::BIT_LIFT]
        |=> !supply_lift_ctl)
        else $error("lift resistor not switched off");

    AST_SUPPLY_EN: assert property ( // R13
        reg_req.wr && reg_req.addr == ovs_pkg::ADDR_OTG
            && (reg_req.wdata[ovs_pkg::BIT_INT_DRIVE] || reg_req.wdata[ovs_pkg::BIT_EXT_DRIVE])
        |=> ext_supply_enable_out)
        else $error("supply enable not asserted");

    AST_UART_LEVEL: assert property ( // R15
        s_uart_enter |=> uart_active && regulator_level == $past(uart_lvl))
        else $error("uart regulator level not applied");

    AST_UART_LINES: assert property ( // R16
        uart_active |-> linestate_data == 2'h0)
        else $error("line levels shown in uart mode");

    AST_SYNC_DELAY: assert property ( // R17
        !$past(sys_rst) && !$past(sys_rst, 2)
        |-> sync_cmp.session_present == $past(cmp_raw.session_present, 2))
        else $error("synchroniser delay wrong");

    AST_SET_WINS: assert property (
        evt[ovs_pkg::BIT_SESSION_PRESENT] && clr[ovs_pkg::BIT_SESSION_PRESENT]
        |=> st_ff.latch[ovs_pkg::BIT_SESSION_PRESENT])
        else $error("event lost against clear");

    sequence s_uart_leave;
        reg_req.wr && reg_req.addr == ovs_pkg::ADDR_IO_PWR
            && !reg_req.wdata[ovs_pkg::BIT_UART_MODE] ##1 1'b1;
    endsequence

    AST_UART_LEAVE: assert property ( // R15
        s_uart_leave |=> !uart_active && regulator_level == $past(norm_lvl))
        else $error("normal regulator level not restored");

    AST_DRAIN_OFF: assert property ( // R10
        reg_req.wr && reg_req.addr == ovs_pkg::ADDR_OTG && !reg_req.wdata[ovs_pkg::BIT_DRAIN]
        |=> !supply_drain_ctl)
        else $error("drain resistor not switched off");

    AST_LIFT_ON: assert property ( // R11
        reg_req.wr && reg_req.addr == ovs_pkg::ADDR_OTG && reg_req.wdata[ovs_pkg::BIT_LIFT]
        |=> supply_lift_ctl)
        else $error("lift resistor not switched on");

    AST_SUPPLY_OFF: assert property ( // R13
        reg_req.wr && reg_req.addr == ovs_pkg::ADDR_OTG
            && !reg_req.wdata[ovs_pkg::BIT_INT_DRIVE]
            && !reg_req.wdata[ovs_pkg::BIT_EXT_DRIVE]
        |=> !ext_supply_enable_out)
        else $error("supply enable not released");

    AST_PASS_ONE: assert property ( // R8
        st_ff.ext_cfg.use_ext && st_ff.ext_cfg.pass && !st_ff.ext_cfg.compl
        |=> rxcmd_vbus_state == ovs_pkg::VBUS_VALID)
        else $error("pass-through did not force one");

    AST_EXT_INTERNAL: assert property ( // R8
        st_ff.ext_cfg.use_ext && !st_ff.ext_cfg.pass && !st_ff.ext_cfg.compl
        |=> (rxcmd_vbus_state == ovs_pkg::VBUS_VALID) == $past(live.supply_good))
        else $error("internal source not reported under select");

    AST_PRESENT_NO_EVT: assert property ( // R3
        !st_ff.en_rise[ovs_pkg::BIT_SESSION_PRESENT]
            && !st_ff.en_fall[ovs_pkg::BIT_SESSION_PRESENT]
            && !st_ff.latch[ovs_pkg::BIT_SESSION_PRESENT]
        |=> !st_ff.latch[ovs_pkg::BIT_SESSION_PRESENT])
        else $error("session-present latched with its interrupts off");

    AST_SYNC_GOOD: assert property ( // R17
        !$past(sys_rst) && !$past(sys_rst, 2)
        |-> sync_cmp.supply_good == $past(cmp_raw.supply_good, 2))
        else $error("supply-good synchroniser delay wrong");
endmodule // ovs_core
`default_nettype wire

// ==== hdl/ovs_pkg.sv ====
// shared constants and types of the supply monitor and supply control block
package ovs_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_EN_RISE = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_EN_FALL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_LATCH   = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_MASK    = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_OTG     = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_IO_PWR  = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_EXT_CFG = 4'h7;

    // comparator bit positions in enable, status, latch and mask
    localparam int BIT_SUPPLY_GOOD     = 1;
    localparam int BIT_SESSION_PRESENT = 2;
    localparam int BIT_SESSION_OVER    = 3;
    localparam logic [DATA_W-1:0] STAT_MASK = 8'h0e;

    // otg control bits
    localparam int BIT_DRAIN     = 3;
    localparam int BIT_LIFT      = 4;
    localparam int BIT_INT_DRIVE = 5;
    localparam int BIT_EXT_DRIVE = 6;
    localparam logic [DATA_W-1:0] OTG_MASK = 8'h78;

    // io and power bits
    localparam int BIT_UART_MODE = 0;
    localparam int UART_LVL_LSB  = 1;
    localparam int NORM_LVL_LSB  = 3;
    localparam int LVL_W         = 2;

    // reset values and the tied indicator level
    localparam logic [DATA_W-1:0] EN_RST  = 8'h0e;
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    localparam logic              EXT_IND_TIED = 1'b1;

    typedef enum logic [1:0] {
        VBUS_BELOW_END     = 2'h0,
        VBUS_END_TO_SESS   = 2'h1,
        VBUS_SESS_TO_VALID = 2'h2,
        VBUS_VALID         = 2'h3
    } ovs_vbus_e;

    typedef enum logic {
        MODE_SYNC = 1'h0,
        MODE_UART = 1'h1
    } ovs_mode_e;

    typedef struct packed {
        logic session_over;
        logic session_present;
        logic supply_good;
    } ovs_cmp_s;

    typedef struct packed {
        logic compl;
        logic pass;
        logic use_ext;
    } ovs_ext_cfg_s;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ovs_bus_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] en_rise;
        logic [DATA_W-1:0] en_fall;
        logic [DATA_W-1:0] latch;
        logic [DATA_W-1:0] mask;
        logic [DATA_W-1:0] otg;
        logic [DATA_W-1:0] io_pwr;
        ovs_ext_cfg_s      ext_cfg;
        ovs_cmp_s          prev;
        logic [DATA_W-1:0] rdata;
        ovs_vbus_e         rxcmd;
        ovs_mode_e         mode;
        logic [LVL_W-1:0]  reg_lvl;
        logic [1:0]        linestate;
    } ovs_state_s;

endpackage

// ==== hdl/ovs_sync.sv ====
// two-flop synchroniser for comparator levels
`timescale 1ns/1ns
`default_nettype none
module ovs_sync #(
    parameter int W = 3
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] hold;
    } ovs_sync_s;

    ovs_sync_s st_ff;
    ovs_sync_s nxt_st;

    // meta is read by hold only
    always_comb begin
        nxt_st.meta = d;
        nxt_st.hold = st_ff.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.hold;
endmodule // ovs_sync
`default_nettype wire

// ==== hdl/ovs_vbus_src.sv ====
// decode of the supply-valid source reported in receive commands
`timescale 1ns/1ns
`default_nettype none
module ovs_vbus_src (
    input  wire logic                 internal_good,
    input  wire ovs_pkg::ovs_ext_cfg_s cfg,
    output logic                      vbus_valid
);
    logic ext_ind;

    // R5: indicator tied high
    assign ext_ind = ovs_pkg::EXT_IND_TIED;

    always_comb begin
        // R7: internal source when select clear
        if (!cfg.use_ext) begin
            vbus_valid = internal_good;
        // R8: complement forces zero
        end else if (cfg.compl) begin
            vbus_valid = 1'b0;
        end else if (cfg.pass) begin
            vbus_valid = ext_ind;
        end else begin
            vbus_valid = internal_good;
        end
    end
endmodule // ovs_vbus_src
`default_nettype wire

// ==== testbench/ovs_link_model.sv ====
// link-side register master model for the supply monitor block
`timescale 1ns/1ns
`default_nettype none
module ovs_link_model (
    input  wire logic [ovs_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                       sys_clk,
    output ovs_pkg::ovs_bus_req_s           reg_req
);
    initial reg_req = '0;

    // strobes held one cycle, released at the edge that takes them
    task automatic wr_reg(input logic [ovs_pkg::ADDR_W-1:0] a,
                          input logic [ovs_pkg::DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask

    // data sampled at the edge closing the answer cycle
    task automatic rd_reg(input logic [ovs_pkg::ADDR_W-1:0] a,
                          output logic [ovs_pkg::DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        reg_req <= '0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask

    task automatic wait_session(output logic ok);
        logic [ovs_pkg::DATA_W-1:0] s;
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            rd_reg(ovs_pkg::ADDR_STATUS, s);
            ok = s[ovs_pkg::BIT_SESSION_PRESENT];
        end
    endtask
endmodule // ovs_link_model
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the supply monitor and supply control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic                  sys_clk = 1'b0;
    logic                  sys_rst = 1'b1;
    ovs_pkg::ovs_bus_req_s reg_req;
    logic [7:0]            reg_rdata;
    ovs_pkg::ovs_cmp_s     cmp_raw = 3'b011;
    logic [1:0]            linestate_in = 2'b11;
    logic                  cmp_supply_good_en;
    logic                  cmp_session_over_en;
    logic                  supply_drain_ctl;
    logic                  supply_lift_ctl;
    logic                  ext_supply_enable_out;
    logic [1:0]            regulator_level;
    logic                  uart_active;
    logic [1:0]            rxcmd_vbus_state;
    logic [1:0]            linestate_data;
    logic                  irq;
    int                    failures = 0;
    int                    tests_run = 0;
    int                    cycles = 0;

    always #5 sys_clk = ~sys_clk;

    ovs_core dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .cmp_raw(cmp_raw), .linestate_in(linestate_in),
        .cmp_supply_good_en(cmp_supply_good_en), .cmp_session_over_en(cmp_session_over_en),
        .supply_drain_ctl(supply_drain_ctl), .supply_lift_ctl(supply_lift_ctl),
        .ext_supply_enable_out(ext_supply_enable_out), .regulator_level(regulator_level),
        .uart_active(uart_active), .rxcmd_vbus_state(rxcmd_vbus_state),
        .linestate_data(linestate_data), .irq(irq)
    );

    ovs_link_model link (.reg_rdata(reg_rdata), .sys_clk(sys_clk), .reg_req(reg_req));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // whole run needs well under two thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        link.wr_reg(a, d);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        link.rd_reg(a, d);
        check(d & m, e);
    endtask

    task automatic set_raw(input logic [2:0] v);
        @(posedge sys_clk);
        cmp_raw <= v;
    endtask

    task automatic t_reset();
        settle(4);
        check({7'h00, ext_supply_enable_out}, 8'h00);
        check({7'h00, irq}, 8'h00);
        check({6'h00, rxcmd_vbus_state}, 8'h03);
        rdc(ovs_pkg::ADDR_EN_RISE, 8'hff, 8'h0e);
        rdc(ovs_pkg::ADDR_EN_FALL, 8'hff, 8'h0e);
        rdc(ovs_pkg::ADDR_OTG, 8'hff, 8'h00);
        rdc(ovs_pkg::ADDR_EXT_CFG, 8'hff, 8'h00);
        wr(4'hf, 8'h5a);
        wr(ovs_pkg::ADDR_STATUS, 8'hff);
        rdc(4'hf, 8'hff, 8'h00);
        rdc(ovs_pkg::ADDR_STATUS, 8'hff, 8'h06);
        $display("test reset done");
    endtask

    task automatic t_otg();
        for (int i = 3; i < 7; i++) begin
            wr(ovs_pkg::ADDR_OTG, 8'h01 << i);
            settle(2);
            check({7'h00, supply_drain_ctl}, {7'h00, i == 3});
            check({7'h00, supply_lift_ctl}, {7'h00, i == 4});
            check({7'h00, ext_supply_enable_out}, {7'h00, i > 4});
        end
        wr(ovs_pkg::ADDR_OTG, 8'hff);
        rdc(ovs_pkg::ADDR_OTG, 8'hff, 8'h78);
        check({7'h00, ext_supply_enable_out}, 8'h01);
        wr(ovs_pkg::ADDR_OTG, 8'h00);
        settle(2);
        check({7'h00, ext_supply_enable_out}, 8'h00);
        $display("test otg done");
    endtask

    task automatic t_comparators();
        logic ok;
        wr(ovs_pkg::ADDR_MASK, 8'h08);
        wr(ovs_pkg::ADDR_LATCH, 8'h0e);
        settle(2);
        check({7'h00, irq}, 8'h00);
        set_raw(3'b100);
        settle(1);
        check({6'h00, rxcmd_vbus_state}, 8'h03);
        settle(4);
        check({6'h00, rxcmd_vbus_state}, 8'h00);
        check({7'h00, irq}, 8'h01);
        rdc(ovs_pkg::ADDR_STATUS, 8'hff, 8'h08);
        rdc(ovs_pkg::ADDR_LATCH, 8'h08, 8'h08);
        wr(ovs_pkg::ADDR_MASK, 8'h00);
        settle(2);
        check({7'h00, irq}, 8'h00);
        wr(ovs_pkg::ADDR_MASK, 8'h08);
        wr(ovs_pkg::ADDR_LATCH, 8'h0e);
        settle(2);
        check({7'h00, irq}, 8'h00);
        wr(ovs_pkg::ADDR_EN_RISE, 8'h06);
        wr(ovs_pkg::ADDR_EN_FALL, 8'h06);
        rdc(ovs_pkg::ADDR_STATUS, 8'hff, 8'h00);
        check({7'h00, cmp_session_over_en}, 8'h00);
        wr(ovs_pkg::ADDR_EN_RISE, 8'h02);
        wr(ovs_pkg::ADDR_EN_FALL, 8'h02);
        wr(ovs_pkg::ADDR_LATCH, 8'h0e);
        set_raw(3'b010);
        settle(4);
        rdc(ovs_pkg::ADDR_STATUS, 8'hff, 8'h04);
        rdc(ovs_pkg::ADDR_LATCH, 8'h04, 8'h00);
        link.wait_session(ok);
        check({7'h00, ok}, 8'h01);
        set_raw(3'b011);
        wr(ovs_pkg::ADDR_EN_RISE, 8'h00);
        wr(ovs_pkg::ADDR_EN_FALL, 8'h00);
        settle(4);
        rdc(ovs_pkg::ADDR_STATUS, 8'hff, 8'h04);
        check({7'h00, cmp_supply_good_en}, 8'h00);
        wr(ovs_pkg::ADDR_EN_RISE, 8'h0e);
        wr(ovs_pkg::ADDR_EN_FALL, 8'h0e);
        $display("test comparators done");
    endtask

    task automatic t_ext_indicator();
        logic v;
        for (int g = 0; g < 2; g++) begin
            set_raw({2'b01, g[0]});
            for (int c = 0; c < 8; c++) begin
                wr(ovs_pkg::ADDR_EXT_CFG, 8'(c));
                settle(4);
                v = !c[0] ? g[0] : (c[2] ? 1'b0 : (c[1] ? 1'b1 : g[0]));
                check({6'h00, rxcmd_vbus_state}, v ? 8'h03 : 8'h02);
            end
        end
        wr(ovs_pkg::ADDR_EXT_CFG, 8'h00);
        $display("test ext indicator done");
    endtask

    task automatic t_uart();
        // uart on, uart level 2, normal level 1
        wr(ovs_pkg::ADDR_IO_PWR, 8'h0d);
        settle(3);
        check({7'h00, uart_active}, 8'h01);
        check({6'h00, regulator_level}, 8'h02);
        check({6'h00, linestate_data}, 8'h00);
        wr(ovs_pkg::ADDR_IO_PWR, 8'h0c);
        settle(3);
        check({7'h00, uart_active}, 8'h00);
        check({6'h00, regulator_level}, 8'h01);
        check({6'h00, linestate_data}, 8'h03);
        $display("test uart done");
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_otg();
        t_comparators();
        t_ext_indicator();
        t_uart();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
